// ---- swbr_top.sv ----
/*
  Serial word readout: shifts format words in during the frame gate,
  converts them to binary and BCD by a fast count, drives lamps and
  recorder channels, accumulates one word in measurement-chain mode,
  shows memory outputs directly and runs a pulse simulator.
  Assumes all inputs synchronous to pclk; one pclk cycle is one
  high-speed count; registers reached over APB.
*/
// Design decisions made here: the placing of the registers and the APB interface to the registers.
// Operation
// - Shift serial data during frame gate
// - Count fast pulses after gate ends
// - Stop counting when counter equals word
// - Decade counters count alongside binary counter
// - Latch decade value to lamps on match, except in chain mode
// - BCD mode also drives recorder with decades
// - Displays hold until next gate rise
// - Gate rise clears counters, lamps show zero except in chain mode
// - Chain mode accumulates selected word across blocks
// - No accumulation during block start line
// - Word counter reset by word zero
// - Decode words 1-8, selected gate passes
// - Chain totals clear only on manual reset
// - Hold chain total at block end
// - Show memory outputs and strobe directly
// - Stretch short pulses, keep raw copies
// - Simulator injects 0-15 pulses, eight channels
// - Bin-open starts train, comparator ends it
`timescale 1ns/1ps
module swbr_top
  import swbr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instrument format signals
  input wire logic frame_gate_window,
  input wire logic serial_data,
  input wire logic shift_strobe,
  input wire logic word_zero,
  input wire logic block_start,
  // Instrument memory and timing pulses
  input wire logic [7:0] mem_out,
  input wire logic memory_transfer_strobe,
  input wire logic revolution_pulse,
  input wire logic bin_open,
  // Panel and recorder
  output logic [15:0] lamp_bcd,
  output logic [19:0] recorder,
  output logic [7:0] mem_display,
  output logic transfer_display,
  output logic revolution_display,
  output logic [9:0] raw_pulses,
  // Simulator channels
  output logic [7:0] sim_chan,
  // Converted word stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [23:0] out_data
);
  import swbr_pkg::*;

  // All state of the block
  typedef struct packed {
    swbr_state_e state;
    logic gate_d;
    logic blk_d;
    logic [7:0] sr;
    logic [7:0] bin;
    logic [15:0] dec;
    logic [15:0] lamp;
    logic [19:0] rec;
    logic [3:0] word_cnt;
    logic [15:0] acc;
    logic [7:0] blk_cnt;
    logic [1:0] mode;
    logic [3:0] chain_word;
    logic [3:0] sim_cnt;
    logic sim_alt;
    logic sim_en;
    logic sim_odd;
    logic sim_active;
    logic [3:0] sim_done;
    logic [8:0] sim_div;
    logic sim_pulse;
    logic [9:0][10:0] str;
    logic [9:0] str_on;
    logic [9:0] raw;
    logic [1:0][23:0] fifo;
    logic fifo_wp;
    logic fifo_rp;
    logic [1:0] fifo_cnt;
    logic [31:0] prdata;
  } swbr_state_s;

  swbr_state_s st_reg;
  swbr_state_s st_next;

  // Helper decodes
  logic wr_acc;
  logic gate_rise;
  logic gate_fall;
  logic blk_rise;
  logic manual_clr;
  logic [7:0] word_gates;
  logic word_pass;
  logic fifo_full;
  logic fifo_pop;
  logic [9:0] pulse_in;
  logic addr_ok;

  // Decimal increment of four decades
  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    logic carry;
    r = v;
    carry = 1'b1;
    for (int d = 0; d < 4; d++) begin
      if (carry) begin
        if (r[d*4 +: 4] == 4'h9) begin
          r[d*4 +: 4] = 4'h0;
        end else begin
          r[d*4 +: 4] = r[d*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // Bus and edge decodes
  always_comb begin
    wr_acc = psel & penable & pwrite;
    addr_ok = (paddr == OFS_CTRL) | (paddr == OFS_SIM) | (paddr == OFS_STATUS) |
              (paddr == OFS_SHIFT);
    gate_rise = frame_gate_window & ~st_reg.gate_d;
    gate_fall = ~frame_gate_window & st_reg.gate_d;
    blk_rise = block_start & ~st_reg.blk_d;
    manual_clr = wr_acc & (paddr == OFS_CTRL) & pwdata[CTRL_CLR_BIT];
    fifo_full = (st_reg.fifo_cnt == FIFO_DEPTH);
    fifo_pop = (st_reg.fifo_cnt != 2'h0) & out_ready;
    pulse_in = {revolution_pulse, memory_transfer_strobe, mem_out};
    // Word gates for states 1 to 8
    for (int i = 0; i < 8; i++) begin
      word_gates[i] = (st_reg.word_cnt == 4'(i + 1));
    end
    word_pass = (st_reg.chain_word >= WORD_FIRST) && (st_reg.chain_word <= WORD_LAST) &&
                word_gates[3'(st_reg.chain_word - 4'h1)];
  end

  // Next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    st_next.gate_d = frame_gate_window;
    st_next.blk_d = block_start;
    st_next.sim_pulse = 1'b0;
    st_next.raw = pulse_in;

    // Register writes
    if (wr_acc && paddr == OFS_CTRL) begin
      st_next.mode = pwdata[CTRL_MODE_LSB +: 2];
      st_next.chain_word = pwdata[CTRL_WORD_LSB +: 4];
    end
    if (wr_acc && paddr == OFS_SIM) begin
      st_next.sim_cnt = pwdata[SIM_CNT_LSB +: 4];
      st_next.sim_alt = pwdata[SIM_ALT_BIT];
      st_next.sim_en = pwdata[SIM_EN_BIT];
    end

    // Read data captured in setup phase
    if (psel && !penable) begin
      case (paddr)
        OFS_CTRL: st_next.prdata = {22'h0, st_reg.chain_word, st_reg.mode, 4'h0} >> 4;
        OFS_SIM: st_next.prdata = {26'h0, st_reg.sim_en, st_reg.sim_alt, st_reg.sim_cnt};
        OFS_STATUS: st_next.prdata = {6'h0, st_reg.state, st_reg.bin, st_reg.lamp};
        OFS_SHIFT: st_next.prdata = {12'h0, st_reg.word_cnt, st_reg.blk_cnt, st_reg.sr};
        default: st_next.prdata = 32'h0;
      endcase
    end

    // Word counter: word zero resets, each word end advances
    if (word_zero) begin
      st_next.word_cnt = 4'h0;
    end else if (gate_fall) begin
      st_next.word_cnt = st_reg.word_cnt + 4'h1;
    end

    // Conversion sequence
    case (st_reg.state)
      ST_IDLE, ST_HOLD: begin
        if (gate_rise) begin
          st_next.state = ST_SHIFT;
          st_next.sr = 8'h00;
          st_next.bin = 8'h00;
          st_next.dec = 16'h0;
          if (st_reg.mode != MODE_CHAIN) begin
            st_next.lamp = 16'h0;
          end
        end
      end
      ST_SHIFT: begin
        if (!frame_gate_window) begin
          st_next.state = ST_COUNT;
        end else if (shift_strobe) begin
          st_next.sr = {st_reg.sr[6:0], serial_data};
        end
      end
      ST_COUNT: begin
        if (st_reg.bin == st_reg.sr) begin
          // Match: counts gated off, result latched once buffer has room
          if (!fifo_full) begin
            st_next.state = ST_HOLD;
            if (st_reg.mode != MODE_CHAIN) begin
              st_next.lamp = st_reg.dec;
            end
          end
        end else begin
          st_next.bin = st_reg.bin + 8'h01;
          st_next.dec = bcd_inc(st_reg.dec);
          if (st_reg.mode == MODE_CHAIN && word_pass && !block_start) begin
            st_next.acc = bcd_inc(st_reg.acc);
          end
        end
      end
      default: st_next.state = ST_IDLE;
    endcase

    // Block start: count blocks, hold the finished total
    if (blk_rise) begin
      st_next.blk_cnt = st_reg.blk_cnt + 8'h01;
      if (st_reg.mode == MODE_CHAIN) begin
        st_next.lamp = st_reg.acc;
      end
    end
    if (manual_clr) begin
      st_next.acc = 16'h0;
      st_next.blk_cnt = 8'h00;
      if (st_reg.mode == MODE_CHAIN) begin
        st_next.lamp = 16'h0;
      end
    end

    // Recorder channels by mode
    case (st_reg.mode)
      MODE_BCD: st_next.rec = {4'h0, st_next.lamp};
      MODE_CHAIN: st_next.rec = {4'h0, st_next.lamp};
      default: st_next.rec = {2'b00, st_reg.str_on, st_reg.sr};
    endcase

    // Pulse stretchers
    for (int i = 0; i < 10; i++) begin
      if (pulse_in[i]) begin
        st_next.str[i] = 11'(STRETCH_CYC);
      end else if (st_reg.str[i] != 11'h0) begin
        st_next.str[i] = st_reg.str[i] - 11'h001;
      end
      st_next.str_on[i] = (st_next.str[i] != 11'h0);
    end

    // Pulse simulator
    if (bin_open && st_reg.sim_en) begin
      st_next.sim_odd = ~st_reg.sim_odd;
      if (!st_reg.sim_alt || !st_reg.sim_odd) begin
        st_next.sim_active = 1'b1;
        st_next.sim_done = 4'h0;
        st_next.sim_div = 9'h000;
      end
    end else if (st_reg.sim_active) begin
      if (st_reg.sim_done == st_reg.sim_cnt) begin
        st_next.sim_active = 1'b0;
      end else if (st_reg.sim_div == 9'(SIM_DIV_CYC - 1)) begin
        st_next.sim_div = 9'h000;
        st_next.sim_pulse = 1'b1;
        st_next.sim_done = st_reg.sim_done + 4'h1;
      end else begin
        st_next.sim_div = st_reg.sim_div + 9'h001;
      end
    end

    // Two-entry output buffer
    if (st_reg.state == ST_COUNT && st_reg.bin == st_reg.sr && !fifo_full) begin
      st_next.fifo[st_reg.fifo_wp] = {st_reg.bin, st_reg.dec};
      st_next.fifo_wp = ~st_reg.fifo_wp;
    end
    if (fifo_pop) begin
      st_next.fifo_rp = ~st_reg.fifo_rp;
    end
    st_next.fifo_cnt = st_reg.fifo_cnt + 2'(st_next.fifo_wp != st_reg.fifo_wp) -
                       2'(fifo_pop);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.mode <= MODE_RST;
      st_reg.chain_word <= WORD_RST;
      st_reg.sim_cnt <= SIM_CNT_RST;
      st_reg.state <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  always_comb begin
    prdata = st_reg.prdata;
    pready = 1'b1;
    pslverr = psel & penable & ~addr_ok;
    lamp_bcd = st_reg.lamp;
    recorder = st_reg.rec;
    mem_display = st_reg.str_on[7:0];
    transfer_display = st_reg.str_on[8];
    revolution_display = st_reg.str_on[9];
    raw_pulses = st_reg.raw;
    sim_chan = {8{st_reg.sim_pulse}};
    out_valid = (st_reg.fifo_cnt != 2'h0);
    out_data = st_reg.fifo[st_reg.fifo_rp];
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_shift;
    st_reg.state == ST_SHIFT && frame_gate_window && shift_strobe
      |=> st_reg.sr == {$past(st_reg.sr[6:0]), $past(serial_data)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register missed bit");

  property p_count_start;
    st_reg.state == ST_SHIFT && !frame_gate_window |=> st_reg.state == ST_COUNT;
  endproperty
  a_count_start: assert property (p_count_start) else $error("count not started");

  property p_stop;
    st_reg.state == ST_COUNT && st_reg.bin == st_reg.sr && !fifo_full
      |=> st_reg.state == ST_HOLD && $stable(st_reg.bin);
  endproperty
  a_stop: assert property (p_stop) else $error("count not stopped on match");

  property p_dec_track;
    st_reg.state == ST_COUNT && st_reg.bin != st_reg.sr
      |=> st_reg.dec == bcd_inc($past(st_reg.dec)) && st_reg.bin == $past(st_reg.bin) + 8'h01;
  endproperty
  a_dec_track: assert property (p_dec_track) else $error("decades not tracking");

  property p_latch;
    st_reg.state == ST_COUNT && st_reg.bin == st_reg.sr && !fifo_full &&
      st_reg.mode != MODE_CHAIN && !blk_rise |=> lamp_bcd == $past(st_reg.dec);
  endproperty
  a_latch: assert property (p_latch) else $error("lamps not latched");

  property p_bcd_rec;
    st_reg.mode == MODE_BCD && $stable(st_reg.mode) ##1 $stable(st_reg.mode)
      |-> recorder == {4'h0, lamp_bcd};
  endproperty
  a_bcd_rec: assert property (p_bcd_rec) else $error("recorder not showing decades");

  property p_zero;
    gate_rise && st_reg.state == ST_HOLD && st_reg.mode != MODE_CHAIN
      |=> lamp_bcd == 16'h0 && st_reg.bin == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("gate rise did not clear");

  property p_hold;
    st_reg.state == ST_HOLD && !gate_rise && st_reg.mode != MODE_CHAIN && !blk_rise &&
      !manual_clr |=> $stable(lamp_bcd);
  endproperty
  a_hold: assert property (p_hold) else $error("display not held");

  property p_clear;
    manual_clr |=> st_reg.acc == 16'h0 && st_reg.blk_cnt == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("manual clear failed");

  property p_word_zero;
    word_zero |=> st_reg.word_cnt == 4'h0;
  endproperty
  a_word_zero: assert property (p_word_zero) else $error("word counter not reset");

  property p_sim_limit;
    st_reg.sim_done <= st_reg.sim_cnt || !st_reg.sim_active;
  endproperty
  a_sim_limit: assert property (p_sim_limit) else $error("simulator overran count");

  property p_stretch;
    $rose(mem_out[0]) |=> mem_display[0] [*8];
  endproperty
  a_stretch: assert property (p_stretch) else $error("pulse not stretched");

  c_convert: cover property (st_reg.state == ST_COUNT ##1 st_reg.state == ST_HOLD);
  c_chain_acc: cover property (st_reg.mode == MODE_CHAIN && st_reg.acc != 16'h0);
  c_sim: cover property (st_reg.sim_active && st_reg.sim_done == st_reg.sim_cnt);
  c_fifo_full: cover property (fifo_full && !out_ready);
endmodule

// ---- swbr_pkg.sv ----
/*
  Shared constants for the serial word readout block: register map,
  field positions, reset values, mode codes, state codes and timing.
  Assumes a 40 MHz pclk; all times are converted to cycles here.
*/
package swbr_pkg;
  // Clock period in ns
  localparam int CLK_NS = 25;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SIM = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SHIFT = 8'h0c;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WORD_LSB = 2;
  localparam int CTRL_CLR_BIT = 8;
  // Simulator register fields
  localparam int SIM_CNT_LSB = 0;
  localparam int SIM_ALT_BIT = 4;
  localparam int SIM_EN_BIT = 5;
  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [3:0] WORD_RST = 4'h1;
  localparam logic [3:0] SIM_CNT_RST = 4'h0;
  // Readout modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_BCD = 2'h1;
  localparam logic [1:0] MODE_CHAIN = 2'h2;
  // Word gate decode range
  localparam logic [3:0] WORD_FIRST = 4'h1;
  localparam logic [3:0] WORD_LAST = 4'h8;
  // Pulse stretch: least time, rounded up
  localparam int STRETCH_NS = 50000;
  localparam int STRETCH_CYC = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
  // Simulator pulse period: rounded up
  localparam int SIM_PERIOD_NS = 10000;
  localparam int SIM_DIV_CYC = (SIM_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  // Buffer depth
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  // Conversion states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_COUNT = 2'b10,
    ST_HOLD = 2'b11
  } swbr_state_e;
endpackage

// ---- swbr_instr.sv ----
/*
  Instrument side model: frame gate, serial word, timing pulses.
  Assumes a free running pclk; the readout block samples on its rise.
*/
`timescale 1ns/1ps
module swbr_instr (
  // Clock
  input wire logic pclk,
  // Format lines
  output logic frame_gate_window,
  output logic serial_data,
  output logic shift_strobe,
  output logic word_zero,
  output logic block_start,
  // Memory and timing pulses
  output logic [7:0] mem_out,
  output logic memory_transfer_strobe,
  output logic revolution_pulse,
  output logic bin_open
);
  // All lines idle low
  initial begin
    {frame_gate_window, serial_data, shift_strobe, word_zero, block_start} = '0;
    {bin_open, revolution_pulse, memory_transfer_strobe, mem_out} = '0;
  end
  // One word, first bit highest, gap + 1 idle cycles before each bit
  task automatic send_word(input logic [7:0] w, input int gap);
    @(posedge pclk) frame_gate_window <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      repeat (gap + 1) @(posedge pclk);
      serial_data <= w[i];
      shift_strobe <= 1'b1;
      @(posedge pclk);
      shift_strobe <= 1'b0;
      serial_data <= ~w[i]; // Stale bit never held
    end
    @(posedge pclk) frame_gate_window <= 1'b0;
  endtask
  // One cycle of {bin_open, word_zero, rev, strobe, mem}
  task automatic pulse_in(input logic [11:0] v);
    @(posedge pclk);
    {bin_open, word_zero, revolution_pulse, memory_transfer_strobe, mem_out} <= v;
    @(posedge pclk);
    {bin_open, word_zero, revolution_pulse, memory_transfer_strobe, mem_out} <= '0;
  endtask
  // Block start line level
  task automatic set_block(input logic b);
    @(posedge pclk) block_start <= b;
  endtask
endmodule

// ---- test_serial_word_bcd_readout.sv ----
/*
  Self-checking bench of the readout block: APB master, instrument model,
  lfsr words, expectations from bench functions.
  Assumes swbr_pkg and swbr_instr compiled first.
*/
`timescale 1ns/1ps
module test_serial_word_bcd_readout;
  import swbr_pkg::*;
  // Clock, reset and bus
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  // Instrument lines
  logic frame_gate_window, serial_data, shift_strobe, word_zero, block_start;
  logic [7:0] mem_out;
  logic memory_transfer_strobe, revolution_pulse, bin_open;
  // Panel, recorder and stream
  logic [15:0] lamp_bcd;
  logic [19:0] recorder;
  logic [7:0] mem_display, sim_chan;
  logic transfer_display, revolution_display, out_valid;
  logic [9:0] raw_pulses;
  logic out_ready = 1'b0;
  logic [23:0] out_data;
  // Bench state
  int error_cnt = 0, n_compared = 0, n;
  logic [7:0] rnd = 8'h26;
  logic [31:0] rd;
  logic er;
  logic [7:0] ws [3];
  logic [7:0] v;
  // Simulator cases: count, alternate, bins, pulses expected
  logic [3:0] sc [4] = '{4'h3, 4'h0, 4'h1, 4'hf};
  logic sa [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  int sb [4] = '{1, 1, 3, 1};
  int se [4] = '{3, 0, 2, 15};

  // Half period toggle
  always #12.5 pclk = ~pclk;

  swbr_instr u_inst (.pclk, .frame_gate_window, .serial_data, .shift_strobe, .word_zero,
    .block_start, .mem_out, .memory_transfer_strobe, .revolution_pulse, .bin_open);
  swbr_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frame_gate_window, .serial_data, .shift_strobe, .word_zero,
    .block_start, .mem_out, .memory_transfer_strobe, .revolution_pulse, .bin_open,
    .lamp_bcd, .recorder, .mem_display, .transfer_display, .revolution_display,
    .raw_pulses, .sim_chan, .out_valid, .out_ready, .out_data);

  // Next lfsr value
  function automatic logic [7:0] nxt();
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    return rnd;
  endfunction
  // Four decades, units low
  function automatic logic [15:0] bcd(input int x);
    return {4'(x / 1000 % 10), 4'(x / 100 % 10), 4'(x / 10 % 10), 4'(x % 10)};
  endfunction
  // Counts and verdict
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; read data and error into rd, er
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
      if (k > 50) begin
        error_cnt++;
        conclude();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Wait for a stream word, compare and pop it
  task automatic pop(input logic [7:0] w);
    n = 0;
    @(negedge pclk);
    while (out_valid !== 1'b1) begin
      @(negedge pclk);
      n++;
      if (n > 600) begin
        error_cnt++;
        conclude();
      end
    end
    chk(out_data, {w, bcd(w)}, "stream word");
    @(posedge pclk) out_ready <= 1'b1;
    @(posedge pclk) out_ready <= 1'b0;
    @(negedge pclk);
  endtask
  // One data line: word zero, then four words with x in position 3
  task automatic chain_line(input logic [7:0] x);
    u_inst.pulse_in(12'h400);
    for (int k = 1; k <= 4; k++) begin
      u_inst.send_word((k == 3) ? x : nxt(), 0);
      repeat (300) @(posedge pclk);
    end
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only and unmapped places
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, {26'h0, WORD_RST, MODE_RST}, "ctrl reset");
    apb(1'b1, OFS_STATUS, 32'hffffffff);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0, "status ro");
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    // Normal mode, three words against a stalled stream
    ws = '{8'h00, 8'hff, nxt()};
    for (int k = 0; k < 3; k++) begin
      u_inst.send_word(ws[k], k);
      repeat (300) @(posedge pclk);
    end
    foreach (ws[k]) pop(ws[k]);
    @(posedge pclk) out_ready <= 1'b1;
    repeat (10) @(negedge pclk);
    chk(lamp_bcd, bcd(ws[2]), "lamps");
    chk(recorder[7:0], ws[2], "rec shift");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[23:16], ws[2], "binary");
    // Short pulses stretched, raw copies kept
    v = nxt();
    u_inst.pulse_in({4'h3, v});
    @(negedge pclk);
    chk(raw_pulses, {2'b11, v}, "raw");
    repeat (STRETCH_CYC - 10) @(negedge pclk);
    chk({revolution_display, transfer_display, mem_display}, {2'b11, v}, "held");
    chk(recorder[17:8], {2'b11, v}, "rec stretch");
    repeat (20) @(negedge pclk);
    chk(mem_display, 8'h00, "stretch end");
    // Decimal mode, then the next gate clears
    apb(1'b1, OFS_CTRL, 32'h5);
    v = nxt();
    u_inst.send_word(v, 2);
    repeat (300) @(negedge pclk);
    chk(recorder, {4'h0, bcd(v)}, "rec bcd");
    fork u_inst.send_word(nxt(), 0); join_none
    repeat (4) @(negedge pclk);
    chk(lamp_bcd, 16'h0, "gate clears");
    repeat (300) @(posedge pclk);
    // Accumulate word 3; first line under block start
    apb(1'b1, OFS_CTRL, 32'h10e);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'he, "ctrl accum");
    v = nxt();
    u_inst.set_block(1'b1);
    chain_line(v);
    u_inst.set_block(1'b0);
    chain_line(v);
    chain_line(v);
    u_inst.set_block(1'b1);
    repeat (4) @(negedge pclk);
    chk(lamp_bcd, bcd(2 * v), "total");
    chk(recorder, {4'h0, bcd(2 * v)}, "rec total");
    u_inst.send_word(v, 0);
    repeat (300) @(negedge pclk);
    chk(lamp_bcd, bcd(2 * v), "total kept");
    apb(1'b1, OFS_CTRL, 32'h10e);
    repeat (4) @(negedge pclk);
    chk(lamp_bcd, 16'h0, "manual clear");
    // Pulse simulator cases
    apb(1'b1, OFS_SIM, 32'h1f);
    apb(1'b0, OFS_SIM, 32'h0);
    chk(rd, 32'h1f, "sim rw");
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, OFS_SIM, 32'h0);
      apb(1'b1, OFS_SIM, {26'h0, 1'b1, sa[t], sc[t]});
      n = 0;
      repeat (sb[t]) begin
        u_inst.pulse_in(12'h800);
        repeat (sc[t] * SIM_DIV_CYC + 500) begin
          @(negedge pclk);
          n += int'(sim_chan === 8'hff);
        end
      end
      chk(n, se[t], "sim count");
    end
    conclude();
  end
endmodule
